/* include/ctl_xfer_pkg.sv */
/*
 * Constants, types and reset values for the control-transfer decode and timing block.
 * Assumes a single 250 MHz core clock; all counts except BOUND_XFERS are in processor clocks.
 */
package ctl_xfer_pkg;

    localparam logic [7:0]  OP_RET_NEAR     = 8'hc3;
    localparam logic [7:0]  OP_RET_NEAR_IMM = 8'hc2;
    localparam logic [7:0]  OP_RET_FAR      = 8'hcb;
    localparam logic [7:0]  OP_RET_FAR_IMM  = 8'hca;
    localparam logic [3:0]  OP_JCC_HI       = 4'h7;
    localparam logic [7:0]  OP_JUMP_IF_COUNT_ZERO         = 8'he3;
    localparam logic [7:0]  OP_LOOP         = 8'he2;
    localparam logic [7:0]  OP_LOOPZ        = 8'he1;
    localparam logic [7:0]  OP_LOOPNZ       = 8'he0;
    localparam logic [7:0]  OP_ENTER        = 8'hc8;
    localparam logic [7:0]  OP_LEAVE        = 8'hc9;
    localparam logic [7:0]  OP_OVERFLOW_TRAP         = 8'hce;
    localparam logic [7:0]  OP_INTERRUPT_RETURN         = 8'hcf;
    localparam logic [7:0]  OP_BOUND        = 8'h62;

    localparam logic [15:0] CYC_RET_NEAR_16 = 16'h0010;
    localparam logic [15:0] CYC_RET_NEAR_8  = 16'h0014;
    localparam logic [15:0] CYC_RET_IMM_16  = 16'h0012;
    localparam logic [15:0] CYC_RET_IMM_8   = 16'h0016;
    localparam logic [15:0] CYC_RET_FAR_16  = 16'h0016;
    localparam logic [15:0] CYC_RET_FAR_8   = 16'h001e;
    localparam logic [15:0] CYC_RETF_IMM_16 = 16'h0019;
    localparam logic [15:0] CYC_RETF_IMM_8  = 16'h0021;
    localparam logic [15:0] CYC_JCC_NOT     = 16'h0004;
    localparam logic [15:0] CYC_JCC_TAKEN   = 16'h000d;
    localparam logic [15:0] CYC_JUMP_IF_COUNT_ZERO_NOT    = 16'h0005;
    localparam logic [15:0] CYC_JUMP_IF_COUNT_ZERO_TAKEN  = 16'h000f;
    localparam logic [15:0] CYC_LOOP_EXIT   = 16'h0006;
    localparam logic [15:0] CYC_LOOP_BACK   = 16'h0010;
    localparam logic [15:0] CYC_ENTER0_16   = 16'h000f;
    localparam logic [15:0] CYC_ENTER0_8    = 16'h0013;
    localparam logic [15:0] CYC_ENTER1_16   = 16'h0019;
    localparam logic [15:0] CYC_ENTER1_8    = 16'h001d;
    localparam logic [15:0] CYC_ENTERN_16   = 16'h0016;
    localparam logic [15:0] CYC_ENTERN_8    = 16'h001a;
    localparam logic [15:0] CYC_LEAVE       = 16'h0008;
    localparam logic [15:0] CYC_OVERFLOW_TRAP_TAKEN  = 16'h0030;
    localparam logic [15:0] CYC_OVERFLOW_TRAP_NOT    = 16'h0004;
    localparam logic [15:0] CYC_INTERRUPT_RETURN        = 16'h001c;
    localparam logic [15:0] CYC_BOUND_MIN   = 16'h0021;
    localparam logic [15:0] CYC_BOUND_MAX   = 16'h0023;
    localparam logic [15:0] CYC_WORD_XFER   = 16'h0004;
    localparam logic [15:0] BOUND_XFERS     = 16'h0002;
    localparam logic [15:0] CYC_BOUND_WORD  = CYC_WORD_XFER * BOUND_XFERS;

    localparam int FL_C = 4;
    localparam int FL_Z = 3;
    localparam int FL_S = 2;
    localparam int FL_O = 1;
    localparam int FL_P = 0;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_OPER = 3'b010,
        ST_EXEC = 3'b100
    } phase_t;

    typedef struct packed {
        phase_t          phase;
        logic            bus8;
        logic            word;
        logic [7:0]      opcode;
        logic [15:0]     ip;
        logic [4:0]      fl;
        logic [15:0]     cx;
        logic [2:0][7:0] bytes;
        logic [1:0]      idx;
        logic [1:0]      need;
        logic [15:0]     cnt;
        logic            byte_ready;
        logic            done;
        logic            taken;
        logic [15:0]     next_ip;
        logic [15:0]     sp_adjust;
        logic [15:0]     frame_size;
        logic [7:0]      nest_level;
        logic            count_write;
        logic [15:0]     count_value;
        logic            overflow_trap;
        logic            unsupported;
        logic [15:0]     cycles;
    } ctl_state_t;

    localparam ctl_state_t CTL_RESET = '{phase: ST_IDLE, byte_ready: 1'b1, default: '0};

endpackage

/* hw/ctl_xfer_decode.sv */
/*
 * Decode and execution timing of the control-transfer instruction group.
 * Assumes the bus unit presents instruction bytes with a valid strobe on core_clk,
 * and that flags, count register and instruction address come from core_clk logic.
 */
`timescale 1ns/10ps

module ctl_xfer_decode (
    input  logic        core_clk,
    input  logic        srst,
    input  logic        bus8_variant,
    input  logic        word_op,
    input  logic        byte_valid,
    input  logic [7:0]  byte_data,
    input  logic [15:0] instr_ip,
    input  logic        carry_flag,
    input  logic        zero_flag,
    input  logic        sign_flag,
    input  logic        overflow_flag,
    input  logic        parity_flag,
    input  logic [15:0] count_register,
    output logic        byte_ready,
    output logic        done,
    output logic        taken,
    output logic [15:0] next_ip,
    output logic [15:0] sp_adjust,
    output logic [15:0] frame_size,
    output logic [7:0]  nest_level,
    output logic        count_write,
    output logic [15:0] count_value,
    output logic        overflow_trap,
    output logic        unsupported,
    output logic [15:0] cycles
);
    import ctl_xfer_pkg::*;

    ctl_state_t  s_reg;
    ctl_state_t  s_next;
    logic        fin;
    logic        tk;
    logic [15:0] fall;
    logic [15:0] h_cnt_reg;

    function automatic logic is_loop(input logic [7:0] op);
        is_loop = (op == OP_LOOP) || (op == OP_LOOPZ) || (op == OP_LOOPNZ);
    endfunction

    function automatic logic is_short(input logic [7:0] op);
        is_short = (op[7:4] == OP_JCC_HI) || is_loop(op) || (op == OP_JUMP_IF_COUNT_ZERO);
    endfunction

    function automatic logic [1:0] oper_len(input logic [7:0] op);
        if (op == OP_RET_NEAR_IMM || op == OP_RET_FAR_IMM) begin
            oper_len = 2'h2;
        end else if (op == OP_ENTER) begin
            oper_len = 2'h3;
        end else if (is_short(op) || op == OP_BOUND) begin
            oper_len = 2'h1;
        end else begin
            oper_len = 2'h0;
        end
    endfunction

    function automatic logic known(input logic [7:0] op);
        known = is_short(op) || (op == OP_RET_NEAR) || (op == OP_RET_NEAR_IMM)
              || (op == OP_RET_FAR) || (op == OP_RET_FAR_IMM) || (op == OP_ENTER)
              || (op == OP_LEAVE) || (op == OP_OVERFLOW_TRAP) || (op == OP_INTERRUPT_RETURN)
              || (op == OP_BOUND);
    endfunction

    // Displacement bytes that follow the mod-reg-r/m byte of the bounds check.
    function automatic logic [1:0] disp_len(input logic [7:0] modrm);
        if (modrm[7:6] == 2'h1) begin
            disp_len = 2'h1;
        end else if (modrm[7:6] == 2'h2) begin
            disp_len = 2'h2;
        end else if (modrm[7:6] == 2'h0 && modrm[2:0] == 3'h6) begin
            disp_len = 2'h2;
        end else begin
            disp_len = 2'h0;
        end
    endfunction

    function automatic logic cond_met(input logic [3:0] cc, input logic [4:0] f);
        logic base;
        case (cc[3:1])
            3'h0: base = f[FL_O];
            3'h1: base = f[FL_C];
            3'h2: base = f[FL_Z];
            3'h3: base = f[FL_C] | f[FL_Z];
            3'h4: base = f[FL_S];
            3'h5: base = f[FL_P];
            3'h6: base = f[FL_S] ^ f[FL_O];
            default: base = (f[FL_S] ^ f[FL_O]) | f[FL_Z];
        endcase
        cond_met = base ^ cc[0];
    endfunction

    function automatic logic [15:0] op_cycles(input logic [7:0] op, input logic b8,
                                              input logic t, input logic w,
                                              input logic [7:0] lvl, input logic [1:0] ext);
        logic [15:0] l16;
        l16 = {8'h00, lvl} - 16'h0001;
        op_cycles = CYC_LEAVE;
        if (op[7:4] == OP_JCC_HI) begin
            op_cycles = t ? CYC_JCC_TAKEN : CYC_JCC_NOT;
        end else if (op == OP_JUMP_IF_COUNT_ZERO) begin
            op_cycles = t ? CYC_JUMP_IF_COUNT_ZERO_TAKEN : CYC_JUMP_IF_COUNT_ZERO_NOT;
        end else if (is_loop(op)) begin
            op_cycles = t ? CYC_LOOP_BACK : CYC_LOOP_EXIT;
        end else if (op == OP_RET_NEAR) begin
            op_cycles = b8 ? CYC_RET_NEAR_8 : CYC_RET_NEAR_16;
        end else if (op == OP_RET_NEAR_IMM) begin
            op_cycles = b8 ? CYC_RET_IMM_8 : CYC_RET_IMM_16;
        end else if (op == OP_RET_FAR) begin
            op_cycles = b8 ? CYC_RET_FAR_8 : CYC_RET_FAR_16;
        end else if (op == OP_RET_FAR_IMM) begin
            op_cycles = b8 ? CYC_RETF_IMM_8 : CYC_RETF_IMM_16;
        end else if (op == OP_ENTER && lvl == 8'h00) begin
            op_cycles = b8 ? CYC_ENTER0_8 : CYC_ENTER0_16;
        end else if (op == OP_ENTER && lvl == 8'h01) begin
            op_cycles = b8 ? CYC_ENTER1_8 : CYC_ENTER1_16;
        end else if (op == OP_ENTER) begin
            op_cycles = b8 ? CYC_ENTERN_8 + (l16 << 4) + (l16 << 2)
                           : CYC_ENTERN_16 + (l16 << 4);
        end else if (op == OP_OVERFLOW_TRAP) begin
            op_cycles = t ? CYC_OVERFLOW_TRAP_TAKEN : CYC_OVERFLOW_TRAP_NOT;
        end else if (op == OP_INTERRUPT_RETURN) begin
            op_cycles = CYC_INTERRUPT_RETURN;
        end else if (op == OP_BOUND) begin
            // Displacement fetch accounts for the spread inside the 33 to 35 range.
            op_cycles = CYC_BOUND_MIN + {14'h0000, ext}
                      + (w ? CYC_BOUND_WORD : 16'h0000);
        end
    endfunction

    always_comb begin
        s_next = s_reg;
        fin = 1'b0;
        tk = 1'b0;
        fall = 16'h0000;
        s_next.done = 1'b0;
        s_next.unsupported = 1'b0;
        s_next.count_write = 1'b0;
        s_next.overflow_trap = 1'b0;
        case (s_reg.phase)
            ST_IDLE: begin
                if (byte_valid && s_reg.byte_ready) begin
                    s_next.opcode = byte_data;
                    s_next.ip = instr_ip;
                    s_next.bus8 = bus8_variant;
                    s_next.word = word_op;
                    s_next.fl = {carry_flag, zero_flag, sign_flag, overflow_flag, parity_flag};
                    s_next.cx = count_register;
                    s_next.idx = 2'h0;
                    s_next.need = oper_len(byte_data);
                    if (!known(byte_data)) begin
                        s_next.unsupported = 1'b1;
                    end else if (s_next.need == 2'h0) begin
                        fin = 1'b1;
                    end else begin
                        s_next.phase = ST_OPER;
                    end
                end
            end
            ST_OPER: begin
                if (byte_valid && s_reg.byte_ready) begin
                    s_next.bytes[s_reg.idx] = byte_data;
                    s_next.idx = s_reg.idx + 2'h1;
                    if (s_reg.opcode == OP_BOUND && s_reg.idx == 2'h0) begin
                        s_next.need = s_reg.need + disp_len(byte_data);
                    end
                    fin = (s_next.idx == s_next.need);
                end
            end
            ST_EXEC: begin
                s_next.cnt = s_reg.cnt - 16'h0001;
                if (s_reg.cnt == 16'h0001) begin
                    s_next.phase = ST_IDLE;
                    s_next.done = 1'b1;
                    s_next.count_write = is_loop(s_reg.opcode);
                    s_next.overflow_trap = (s_reg.opcode == OP_OVERFLOW_TRAP) && s_reg.taken;
                end
            end
            default: s_next.phase = ST_IDLE;
        endcase
        if (fin) begin
            fall = s_next.ip + {14'h0000, s_next.need} + 16'h0001;
            if (s_next.opcode[7:4] == OP_JCC_HI) begin
                tk = cond_met(s_next.opcode[3:0], s_next.fl);
            end else if (s_next.opcode == OP_JUMP_IF_COUNT_ZERO) begin
                tk = (s_next.cx == 16'h0000);
            end else if (is_loop(s_next.opcode)) begin
                s_next.count_value = s_next.cx - 16'h0001;
                tk = (s_next.count_value != 16'h0000)
                   && (s_next.opcode == OP_LOOP || s_next.fl[FL_Z] == s_next.opcode[0]);
            end else if (s_next.opcode == OP_OVERFLOW_TRAP) begin
                tk = s_next.fl[FL_O];
            end
            s_next.taken = tk;
            s_next.next_ip = (tk && is_short(s_next.opcode))
                           ? fall + {{8{s_next.bytes[0][7]}}, s_next.bytes[0]} : fall;
            s_next.sp_adjust = (s_next.opcode == OP_RET_NEAR_IMM || s_next.opcode == OP_RET_FAR_IMM)
                             ? {s_next.bytes[1], s_next.bytes[0]} : 16'h0000;
            if (s_next.opcode == OP_ENTER) begin
                s_next.frame_size = {s_next.bytes[1], s_next.bytes[0]};
                s_next.nest_level = s_next.bytes[2];
            end
            s_next.cnt = op_cycles(s_next.opcode, s_next.bus8, tk, s_next.word,
                                   s_next.bytes[2], s_next.need - 2'h1);
            s_next.cycles = s_next.cnt;
            s_next.phase = ST_EXEC;
        end
        // Refusing bytes during execution lets the bus unit hold the next opcode.
        s_next.byte_ready = (s_next.phase != ST_EXEC);
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            s_reg <= CTL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    // Clocks spent in execution, read only by the checks below.
    always_ff @(posedge core_clk) begin
        if (srst || s_reg.phase != ST_EXEC) begin
            h_cnt_reg <= 16'h0000;
        end else begin
            h_cnt_reg <= h_cnt_reg + 16'h0001;
        end
    end

    assign byte_ready = s_reg.byte_ready;
    assign done = s_reg.done;
    assign taken = s_reg.taken;
    assign next_ip = s_reg.next_ip;
    assign sp_adjust = s_reg.sp_adjust;
    assign frame_size = s_reg.frame_size;
    assign nest_level = s_reg.nest_level;
    assign count_write = s_reg.count_write;
    assign count_value = s_reg.count_value;
    assign overflow_trap = s_reg.overflow_trap;
    assign unsupported = s_reg.unsupported;
    assign cycles = s_reg.cycles;

    property p_ret_near;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_RET_NEAR
        |-> h_cnt_reg == (s_reg.bus8 ? CYC_RET_NEAR_8 : CYC_RET_NEAR_16);
    endproperty
    a_ret_near: assert property (p_ret_near) else $error("near return timing wrong");

    property p_ret_imm;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_RET_NEAR_IMM
        |-> h_cnt_reg == (s_reg.bus8 ? CYC_RET_IMM_8 : CYC_RET_IMM_16)
            && sp_adjust == {s_reg.bytes[1], s_reg.bytes[0]};
    endproperty
    a_ret_imm: assert property (p_ret_imm) else $error("near return adjust wrong");

    property p_retf_imm;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_RET_FAR_IMM
        |-> h_cnt_reg == (s_reg.bus8 ? CYC_RETF_IMM_8 : CYC_RETF_IMM_16);
    endproperty
    a_retf_imm: assert property (p_retf_imm) else $error("far return timing wrong");

    property p_jcc;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode[7:4] == OP_JCC_HI
        |-> h_cnt_reg == (taken ? CYC_JCC_TAKEN : CYC_JCC_NOT);
    endproperty
    a_jcc: assert property (p_jcc) else $error("short jump timing wrong");

    property p_jz;
        @(posedge core_clk) disable iff (srst)
        s_reg.phase == ST_EXEC && s_reg.opcode == 8'h74 |-> taken == s_reg.fl[FL_Z];
    endproperty
    a_jz: assert property (p_jz) else $error("equal jump decision wrong");

    property p_jl;
        @(posedge core_clk) disable iff (srst)
        s_reg.phase == ST_EXEC && s_reg.opcode == 8'h7c
        |-> taken == (s_reg.fl[FL_S] != s_reg.fl[FL_O]);
    endproperty
    a_jl: assert property (p_jl) else $error("signed less decision wrong");

    property p_jump_if_count_zero;
        @(posedge core_clk) disable iff (srst)
        $rose(s_reg.phase == ST_EXEC) && s_reg.opcode == OP_JUMP_IF_COUNT_ZERO
        |-> taken == (s_reg.cx == 16'h0000);
    endproperty
    a_jump_if_count_zero: assert property (p_jump_if_count_zero) else $error("count zero jump wrong");

    property p_loop;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_LOOP
        |-> count_write && taken == (count_value != 16'h0000) && count_value == s_reg.cx - 16'h0001;
    endproperty
    a_loop: assert property (p_loop) else $error("loop count wrong");

    property p_enter1;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_ENTER && nest_level == 8'h01
        |-> h_cnt_reg == (s_reg.bus8 ? CYC_ENTER1_8 : CYC_ENTER1_16);
    endproperty
    a_enter1: assert property (p_enter1) else $error("entry level one timing wrong");

    property p_overflow_trap;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_OVERFLOW_TRAP
        |-> overflow_trap == s_reg.fl[FL_O]
            && h_cnt_reg == (s_reg.fl[FL_O] ? CYC_OVERFLOW_TRAP_TAKEN : CYC_OVERFLOW_TRAP_NOT);
    endproperty
    a_overflow_trap: assert property (p_overflow_trap) else $error("overflow trap wrong");

    property p_bound;
        @(posedge core_clk) disable iff (srst)
        done && s_reg.opcode == OP_BOUND && !s_reg.word
        |-> h_cnt_reg >= CYC_BOUND_MIN && h_cnt_reg <= CYC_BOUND_MAX;
    endproperty
    a_bound: assert property (p_bound) else $error("bounds check timing out of range");

    property p_short_target;
        @(posedge core_clk) disable iff (srst)
        done && taken && s_reg.opcode[7:4] == OP_JCC_HI
        |-> next_ip == s_reg.ip + 16'h0002 + {{8{s_reg.bytes[0][7]}}, s_reg.bytes[0]};
    endproperty
    a_short_target: assert property (p_short_target) else $error("branch target wrong");

    property p_busy;
        @(posedge core_clk) disable iff (srst)
        s_reg.phase == ST_EXEC |-> !byte_ready ##1 (done || !byte_ready);
    endproperty
    a_busy: assert property (p_busy) else $error("byte taken during execution");

endmodule // ctl_xfer_decode

/* verif/prog_mem.sv */
/*
 * Program memory model that hands instruction bytes to the decoder one at a time.
 * Assumes byte_ready from the decoder and a program loaded by a one-cycle start pulse.
 */
`timescale 1ns/10ps
module prog_mem (
    input  wire logic            core_clk,
    input  wire logic            srst,
    input  wire logic            start,
    input  wire logic            slow,
    input  wire logic [3:0]      n_bytes,
    input  wire logic [7:0][7:0] prog,
    input  wire logic            byte_ready,
    output logic                 byte_valid,
    output logic [7:0]           byte_data,
    output logic                 empty
);
    logic [3:0] pos_reg;
    logic [3:0] len_reg;
    logic [7:0] last_reg;
    logic       gap_reg;
    always_ff @(posedge core_clk) begin
        if (srst || start) begin
            pos_reg  <= 4'h0;
            len_reg  <= srst ? 4'h0 : n_bytes;
            last_reg <= 8'h00;
            gap_reg  <= 1'b0;
        end else if (byte_valid && byte_ready) begin
            pos_reg  <= pos_reg + 4'h1;
            last_reg <= byte_data;
            gap_reg  <= slow;
        end else begin
            gap_reg  <= 1'b0;
        end
    end
    // Opcode first, then operands with 16-bit fields low byte first.
    assign byte_valid = (pos_reg < len_reg) && !gap_reg && !start;
    // An idle line shows the inverse of the last byte so a stale copy cannot pass.
    assign byte_data  = byte_valid ? prog[pos_reg] : ~last_reg;
    assign empty      = (pos_reg >= len_reg);
endmodule // prog_mem

/* verif/control_transfer_decode_timing_test.sv */
/*
 * Self-checking bench for the control-transfer decoder fed by the program memory model.
 * Assumes a 4 ns core clock and inputs driven 1 ns after each rising edge.
 */
`timescale 1ns/10ps
module control_transfer_decode_timing_test;
    import ctl_xfer_pkg::*;
    logic            core_clk = 1'b0;
    logic            srst = 1'b1;
    logic            start = 1'b0;
    logic            slow = 1'b0;
    logic            bus8_variant = 1'b0;
    logic            word_op = 1'b0;
    logic [4:0]      fl = 5'h00;
    logic [15:0]     instr_ip = 16'h0100;
    logic [15:0]     count_register = 16'h0000;
    logic [3:0]      n_bytes = 4'h0;
    logic [7:0][7:0] prog = '0;
    logic            byte_valid, byte_ready, done, taken, count_write, overflow_trap;
    logic            unsupported, empty;
    logic [7:0]      byte_data, nest_level;
    logic [15:0]     next_ip, sp_adjust, frame_size, count_value, cycles;
    int              num_errors = 0;
    int              comparisons = 0;
    ctl_xfer_decode ctl_xfer_decode_i (.core_clk, .srst, .bus8_variant, .word_op, .byte_valid,
        .byte_data, .instr_ip, .carry_flag(fl[FL_C]), .zero_flag(fl[FL_Z]),
        .sign_flag(fl[FL_S]), .overflow_flag(fl[FL_O]), .parity_flag(fl[FL_P]),
        .count_register, .byte_ready, .done, .taken, .next_ip, .sp_adjust, .frame_size,
        .nest_level, .count_write, .count_value, .overflow_trap, .unsupported, .cycles);
    prog_mem prog_mem_i (.core_clk, .srst, .start, .slow, .n_bytes, .prog, .byte_ready,
        .byte_valid, .byte_data, .empty);
    always #2 core_clk = ~core_clk;
    task automatic chk1(input string nm, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic complete_run();
        $display("comparisons %0d num_errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic step();
        @(posedge core_clk);
        #1;
    endtask
    task automatic run(input logic [31:0] w, input logic [3:0] n, input logic [4:0] f,
                       input logic [15:0] cx, input logic b8, input logic et,
                       input logic [15:0] eip, input logic [15:0] ec);
        int k;
        prog = {32'h0, w};
        n_bytes = n;
        fl = f;
        count_register = cx;
        bus8_variant = b8;
        start = 1'b1;
        step();
        start = 1'b0;
        for (k = 0; empty !== 1'b1 && k < 50; k++)
            step();
        if (et !== 1'bx)
            chk1("taken", et, taken);
        chk16("next_ip", eip, next_ip);
        chk16("cycles", ec, cycles);
        chk1("byte_ready", 1'b0, byte_ready);
        for (k = 0; done !== 1'b1 && k < 300; k++)
            step();
        // The done pulse must land exactly as many edges after the decision as charged.
        chk16("done_edges", ec, k[15:0]);
        chk1("count_write", w[7:2] == 6'h38 && w[1:0] != 2'h3, count_write);
        chk1("overflow_trap", w[7:0] == 8'hce && f[FL_O], overflow_trap);
        chk1("byte_ready", 1'b1, byte_ready);
    endtask
    function automatic logic cond(input logic [3:0] c, input logic [4:0] f);
        logic so;
        so = f[FL_S] ^ f[FL_O];
        case (c[3:1])
            3'd0: cond = f[FL_O];
            3'd1: cond = f[FL_C];
            3'd2: cond = f[FL_Z];
            3'd3: cond = f[FL_C] | f[FL_Z];
            3'd4: cond = f[FL_S];
            3'd5: cond = f[FL_P];
            3'd6: cond = so;
            default: cond = f[FL_Z] | so;
        endcase
        cond = cond ^ c[0];
    endfunction
    task automatic t_returns();
        for (int v = 0; v < 2; v++) begin
            run(32'h000000c3, 1, 0, 0, v[0], 1'bx, 16'h0101, v ? 20 : 16);
            run(32'h001234c2, 3, 0, 0, v[0], 1'bx, 16'h0103, v ? 22 : 18);
            chk16("sp_adjust", 16'h1234, sp_adjust);
            run(32'h000000cb, 1, 0, 0, v[0], 1'bx, 16'h0101, v ? 30 : 22);
            run(32'h00fe01ca, 3, 0, 0, v[0], 1'bx, 16'h0103, v ? 33 : 25);
            chk16("sp_adjust", 16'hfe01, sp_adjust);
        end
    endtask
    task automatic t_branches();
        logic t;
        for (int c = 0; c < 16; c++)
            for (int f = 0; f < 32; f++) begin
                t = cond(c[3:0], f[4:0]);
                run({16'h0, 8'h85, 4'h7, c[3:0]}, 2, f[4:0], 0, f[0] ^ c[0], t,
                    t ? 16'h0087 : 16'h0102, t ? 13 : 4);
            end
    endtask
    task automatic t_counts();
        run(32'h0000fbe3, 2, 0, 16'h0000, 1'b0, 1'b1, 16'h00fd, 15);
        run(32'h0000fbe3, 2, 0, 16'h0001, 1'b1, 1'b0, 16'h0102, 5);
        run(32'h000010e2, 2, 0, 16'h0001, 1'b0, 1'b0, 16'h0102, 6);
        chk16("count_value", 16'h0000, count_value);
        run(32'h000010e2, 2, 0, 16'h0000, 1'b1, 1'b1, 16'h0112, 16);
        chk16("count_value", 16'hffff, count_value);
        run(32'h000010e1, 2, 5'h08, 16'h0002, 1'b0, 1'b1, 16'h0112, 16);
        run(32'h000010e1, 2, 5'h00, 16'h0002, 1'b0, 1'b0, 16'h0102, 6);
        run(32'h000010e0, 2, 5'h00, 16'h0002, 1'b1, 1'b1, 16'h0112, 16);
        run(32'h000010e0, 2, 5'h08, 16'h0002, 1'b1, 1'b0, 16'h0102, 6);
    endtask
    task automatic t_frames();
        // Slow feeding leaves a gap between operand bytes.
        slow = 1'b1;
        for (int v = 0; v < 2; v++) begin
            run(32'h000210c8, 4, 0, 0, v[0], 1'bx, 16'h0104, v ? 19 : 15);
            run(32'h010210c8, 4, 0, 0, v[0], 1'bx, 16'h0104, v ? 29 : 25);
            run(32'h030210c8, 4, 0, 0, v[0], 1'bx, 16'h0104, v ? 66 : 54);
            chk16("frame_size", 16'h0210, frame_size);
            chk16("nest_level", 16'h0003, {8'h00, nest_level});
            run(32'h000000c9, 1, 0, 0, v[0], 1'bx, 16'h0101, 8);
            run(32'h000000cf, 1, 0, 0, v[0], 1'bx, 16'h0101, 28);
            run(32'h000000ce, 1, 5'h02, 0, v[0], 1'b1, 16'h0101, 48);
            run(32'h000000ce, 1, 5'h1d, 0, v[0], 1'b0, 16'h0101, 4);
        end
        slow = 1'b0;
    endtask
    task automatic t_bound();
        run(32'h0000c062, 2, 0, 0, 1'b0, 1'bx, 16'h0102, 33);
        run(32'h00f04662, 3, 0, 0, 1'b1, 1'bx, 16'h0103, 34);
        run(32'h34128662, 4, 0, 0, 1'b0, 1'bx, 16'h0104, 35);
        run(32'h34120662, 4, 0, 0, 1'b0, 1'bx, 16'h0104, 35);
        word_op = 1'b1;
        run(32'h00f04662, 3, 0, 0, 1'b0, 1'bx, 16'h0103, 42);
        word_op = 1'b0;
    endtask
    task automatic t_other();
        instr_ip = 16'hfffe;
        run(32'h00000174, 2, 5'h08, 0, 1'b0, 1'b1, 16'h0001, 13);
        instr_ip = 16'h0100;
        prog = {56'h0, 8'h90};
        n_bytes = 4'd1;
        start = 1'b1;
        step();
        start = 1'b0;
        step();
        chk1("unsupported", 1'b1, unsupported);
        step();
        chk1("unsupported", 1'b0, unsupported);
        run(32'h000000cf, 1, 0, 0, 1'b0, 1'bx, 16'h0101, 28);
        start = 1'b1;
        step();
        start = 1'b0;
        repeat (5) step();
        srst = 1'b1;
        step();
        chk1("byte_ready", 1'b1, byte_ready);
        chk1("taken", 1'b0, taken);
        chk16("cycles", 16'h0000, cycles);
        srst = 1'b0;
        run(32'h000000c3, 1, 0, 0, 1'b1, 1'bx, 16'h0101, 20);
    endtask
    initial begin
        repeat (3) @(posedge core_clk);
        #1 srst = 1'b0;
        t_returns();
        t_branches();
        t_counts();
        t_frames();
        t_bound();
        t_other();
        complete_run();
    end
    initial begin
        #200000;
        num_errors++;
        complete_run();
    end
endmodule // control_transfer_decode_timing_test
